// [hdl/wcs_regs.svh]
`ifndef WCS_REGS_SVH
`define WCS_REGS_SVH
// data widths and counts
`define WCS_WEIGHT_W 24
`define WCS_TALLY_W 14
`define WCS_TOTAL_W 32
`define WCS_CODE_W 7
`define WCS_NUM_CODES 100
`define WCS_TALLY_MAX 14'h270F
`define WCS_WEIGHT_SETTLED_FLAG_CNT 8
`define WCS_FLAG_N 18
// register offsets
`define WCS_ADDR_W 8
`define WCS_OFS_CTRL 8'h00
`define WCS_OFS_CODE 8'h04
`define WCS_OFS_SP1 8'h08
`define WCS_OFS_SP2 8'h0C
`define WCS_OFS_SP3 8'h10
`define WCS_OFS_FINAL 8'h14
`define WCS_OFS_OVER 8'h18
`define WCS_OFS_UNDER 8'h1C
`define WCS_OFS_UPPER 8'h20
`define WCS_OFS_LOWER 8'h24
`define WCS_OFS_NEAR 8'h28
`define WCS_OFS_MD 8'h2C
`define WCS_OFS_DZRNG 8'h30
`define WCS_OFS_TOTLIM 8'h34
`define WCS_OFS_STATUS 8'h38
`define WCS_OFS_TALLY 8'h3C
`define WCS_OFS_TOTAL 8'h40
// control bits
`define WCS_CTRL_SEQ 0
`define WCS_CTRL_DISCHARGE_ACTIVE_FLAG 1
`define WCS_CTRL_SLOCK 2
`define WCS_CTRL_START 3
`define WCS_CTRL_STOP 4
`define WCS_CTRL_DZ 5
`define WCS_CTRL_ACLR 6
// status bits
`define WCS_ST_SP1 0
`define WCS_ST_DONE 3
`define WCS_ST_DISCHARGE_ACTIVE_FLAG 4
`define WCS_ST_OVER 5
`define WCS_ST_GO 6
`define WCS_ST_UNDER 7
`define WCS_ST_HI 8
`define WCS_ST_LO 9
`define WCS_ST_NZ 10
`define WCS_ST_WEIGHT_SETTLED_FLAG 11
`define WCS_ST_ZERO_RANGE_ALARM 12
`define WCS_ST_HLOCK 13
`define WCS_ST_SLOCK 14
`define WCS_ST_TOTAL_LIMIT_FLAG 15
`define WCS_ST_RUN 16
`define WCS_ST_NOV 17
`endif

// [hdl/wcs_pkg.sv]
package wcs_pkg;
`include "wcs_regs.svh"
    typedef logic signed [`WCS_WEIGHT_W-1:0] wcs_weight_type;
    typedef enum logic [1:0]
    {
        WCS_IDLE = 2'b00,
        WCS_FEED = 2'b01,
        WCS_JUDGE = 2'b11,
        WCS_DONE = 2'b10
    } wcs_state_type;
    typedef struct packed
    {
        wcs_weight_type under_tol;
        wcs_weight_type over_tol;
        wcs_weight_type final_w;
        wcs_weight_type sp3;
        wcs_weight_type sp2;
        wcs_weight_type sp1;
    } wcs_set_type;
endpackage

// [hdl/wcs_bank_if.sv]
`timescale 1ns/1ps
interface wcs_bank_if;
    import wcs_pkg::*;
    logic [`WCS_CODE_W-1:0] code;
    logic wr_en;
    logic [2:0] wr_fld;
    wcs_weight_type wr_data;
    wcs_set_type set;
    logic inc;
    wcs_weight_type amount;
    logic clr;
    logic [`WCS_TALLY_W-1:0] tally;
    logic [`WCS_TOTAL_W-1:0] total;
    modport bank (input code, wr_en, wr_fld, wr_data, inc, amount, clr,
        output set, tally, total);
    modport ctrl (output code, wr_en, wr_fld, wr_data, inc, amount, clr,
        input set, tally, total);
endinterface

// [hdl/wcs_recipe_bank.sv]
`timescale 1ns/1ps
module wcs_recipe_bank
    import wcs_pkg::*;
#(
    parameter int NUM_CODES = `WCS_NUM_CODES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // controller side
    wcs_bank_if.bank bus
);
    initial if (NUM_CODES < 1 || NUM_CODES > (1 << `WCS_CODE_W)) $error("bad NUM_CODES");
    wcs_set_type set_mem [NUM_CODES];
    logic [`WCS_TALLY_W-1:0] tally_mem [NUM_CODES];
    logic [`WCS_TOTAL_W-1:0] total_mem [NUM_CODES];
    logic hit;
    assign hit = int'(bus.code) < NUM_CODES;
    // formula sets, one per code
    always_ff @(posedge clk_i)
    begin
        if (bus.wr_en && hit)
        begin
            set_mem[bus.code][bus.wr_fld*`WCS_WEIGHT_W +: `WCS_WEIGHT_W] <= bus.wr_data;
        end
    end
    // per-code tally and total, only the selected code moves
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < NUM_CODES; i++)
            begin
                tally_mem[i] <= '0;
                total_mem[i] <= '0;
            end
        end
        else if (hit && bus.clr)
        begin
            tally_mem[bus.code] <= '0;
            total_mem[bus.code] <= '0;
        end
        else if (hit && bus.inc)
        begin
            if (tally_mem[bus.code] != `WCS_TALLY_MAX)
            begin
                tally_mem[bus.code] <= tally_mem[bus.code] + 1'b1;
            end
            total_mem[bus.code] <= total_mem[bus.code]
                + (`WCS_TOTAL_W)'(bus.amount);
        end
    end
    // lookup of selected code
    assign bus.set = hit ? set_mem[bus.code] : '0;
    assign bus.tally = hit ? tally_mem[bus.code] : '0;
    assign bus.total = hit ? total_mem[bus.code] : '0;
endmodule // wcs_recipe_bank

// [hdl/wcs_motion.sv]
`timescale 1ns/1ps
module wcs_motion
    import wcs_pkg::*;
#(
    parameter int WEIGHT_SETTLED_FLAG_CNT = `WCS_WEIGHT_SETTLED_FLAG_CNT
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // weight and band
    input wcs_weight_type weight_i,
    input wcs_weight_type band_i,
    // result
    output logic settled_o
);
    initial if (WEIGHT_SETTLED_FLAG_CNT < 1 || WEIGHT_SETTLED_FLAG_CNT > 255) $error("bad WEIGHT_SETTLED_FLAG_CNT");
    wcs_weight_type prev_q;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic signed [`WCS_WEIGHT_W:0] delta;
    // count cycles whose change stays inside the band
    always_comb
    begin
        delta = {weight_i[`WCS_WEIGHT_W-1], weight_i} - {prev_q[`WCS_WEIGHT_W-1], prev_q};
        if (delta < 0)
        begin
            delta = -delta;
        end
        cnt_d = cnt_q;
        if (delta > {band_i[`WCS_WEIGHT_W-1], band_i})
        begin
            cnt_d = '0;
        end
        else if (cnt_q != 8'(WEIGHT_SETTLED_FLAG_CNT))
        begin
            cnt_d = cnt_q + 8'h01;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            prev_q <= weight_i;
            cnt_q <= cnt_d;
        end
    end
    assign settled_o = cnt_q == 8'(WEIGHT_SETTLED_FLAG_CNT);
endmodule // wcs_motion

// [hdl/wcs_top.sv]
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - simple mode compares weight to every target
// - reached target asserts its setpoint output
// - sequence start raises all three setpoints
// - each setpoint drops at its own preset
// - start/stop from panel or connector lines
// - feed/discharge switchable during weighing
// - bank of 100 formula sets
// - cycle tally saturates at 9999
// - per-code tally, accumulation clear zeroes it
// - total accumulates only for selected code
// - finished cycle flagged over, go or under
// - near-zero flag when weight at most threshold
// - upper and lower limit flags
// - digital zero outside range raises alarm
// - settled flag depends on motion setting
// - hardware and software lock reported separately
// - total limit flag, else run
// - write-in-progress replaces run indication
// - hardware lock rejects setting changes
module wcs_top
    import wcs_pkg::*;
#(
    parameter int NUM_CODES = `WCS_NUM_CODES,
    parameter int WEIGHT_SETTLED_FLAG_CNT = `WCS_WEIGHT_SETTLED_FLAG_CNT
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [`WCS_ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [31:0] rdata_o,
    // weighing and control inputs
    input wcs_weight_type weight_i,
    input wire logic ext_start_i,
    input wire logic ext_stop_i,
    input wire logic ext_discharge_active_flag_i,
    input wire logic hw_lock_i,
    input wire logic nvm_busy_i,
    // setpoint outputs
    output logic setpoint_out_first_o,
    output logic setpoint_out_second_o,
    output logic setpoint_out_third_o,
    // status flags
    output logic cycle_done_flag_o,
    output logic discharge_active_flag_o,
    output logic over_flag_o,
    output logic go_flag_o,
    output logic under_flag_o,
    output logic upper_limit_flag_o,
    output logic beneath_min_flag_o,
    output logic near_null_flag_o,
    output logic weight_settled_flag_o,
    output logic zero_range_alarm_o,
    output logic hw_lock_flag_o,
    output logic soft_lock_flag_o,
    output logic total_limit_flag_o,
    output logic run_flag_o,
    output logic nov_flag_o
);
    initial if (NUM_CODES < 1 || NUM_CODES > (1 << `WCS_CODE_W)) $error("bad NUM_CODES");
    wcs_bank_if bank_bus ();
    wcs_state_type state_q, state_d;
    logic [6:0] ctrl_q, ctrl_d;
    logic [`WCS_CODE_W-1:0] code_q, code_d;
    wcs_weight_type upper_q, upper_d, lower_q, lower_d, near_q, near_d;
    wcs_weight_type md_q, md_d, dzrng_q, dzrng_d, zero_q, zero_d, base_q, base_d;
    logic [`WCS_TOTAL_W-1:0] totlim_q, totlim_d;
    logic [`WCS_FLAG_N-1:0] flags_q, flags_d;
    logic [31:0] rdata_q, rdata_d;
    logic ext_start_q, ext_stop_q, discharge_active_flag_q;
    wcs_weight_type wt, amount, wr_w, gross_abs;
    wcs_set_type set;
    logic [2:0] cmp_simple, reach;
    logic wr_ctrl, set_ok, start_req, stop_req, dz_req, aclr_req, discharge_active_flag_now, settled, inc;

    // setting writes, refused while the hardware lock is on
    assign wr_ctrl = we_i && addr_i == `WCS_OFS_CTRL;
    assign set_ok = we_i && !hw_lock_i;
    assign wr_w = wdata_i[`WCS_WEIGHT_W-1:0];
    assign set = bank_bus.set;

    // requests from panel or connector
    assign start_req = (wr_ctrl && wdata_i[`WCS_CTRL_START]) || (ext_start_i && !ext_start_q);
    assign stop_req = (wr_ctrl && wdata_i[`WCS_CTRL_STOP]) || (ext_stop_i && !ext_stop_q);
    assign dz_req = wr_ctrl && wdata_i[`WCS_CTRL_DZ];
    assign aclr_req = wr_ctrl && wdata_i[`WCS_CTRL_ACLR];
    assign discharge_active_flag_now = ctrl_q[`WCS_CTRL_DISCHARGE_ACTIVE_FLAG] || ext_discharge_active_flag_i;

    // net weight, amount moved since start, target comparisons
    assign wt = weight_i - zero_q;
    assign amount = discharge_active_flag_now ? base_q - wt : wt - base_q;
    assign gross_abs = weight_i[`WCS_WEIGHT_W-1] ? -weight_i : weight_i;
    assign cmp_simple = {wt >= set.sp3, wt >= set.sp2, wt >= set.sp1};
    assign reach = {amount >= set.sp3, amount >= set.sp2, amount >= set.sp1};

    // bank port
    assign bank_bus.code = code_q;
    assign bank_bus.wr_en = set_ok && addr_i >= `WCS_OFS_SP1 && addr_i <= `WCS_OFS_UNDER
        && addr_i[1:0] == 2'b00;
    assign bank_bus.wr_fld = 3'((addr_i - `WCS_OFS_SP1) >> 2);
    assign bank_bus.wr_data = wr_w;
    assign bank_bus.inc = inc;
    assign bank_bus.amount = amount;
    assign bank_bus.clr = aclr_req;

    wcs_recipe_bank #(.NUM_CODES(NUM_CODES)) u_bank
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .bus(bank_bus.bank)
    );

    wcs_motion #(.WEIGHT_SETTLED_FLAG_CNT(WEIGHT_SETTLED_FLAG_CNT)) u_motion
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .weight_i(wt),
        .band_i(md_q),
        .settled_o(settled)
    );

    // setting registers, zero offset and read data
    always_comb
    begin
        ctrl_d = ctrl_q;
        code_d = code_q;
        upper_d = upper_q;
        lower_d = lower_q;
        near_d = near_q;
        md_d = md_q;
        dzrng_d = dzrng_q;
        totlim_d = totlim_q;
        zero_d = zero_q;
        rdata_d = '0;
        if (wr_ctrl)
        begin
            ctrl_d = {4'h0, wdata_i[2:0]};
        end
        if (we_i && addr_i == `WCS_OFS_CODE)
        begin
            code_d = wdata_i[`WCS_CODE_W-1:0];
        end
        if (set_ok)
        begin
            case (addr_i)
                `WCS_OFS_UPPER: upper_d = wr_w;
                `WCS_OFS_LOWER: lower_d = wr_w;
                `WCS_OFS_NEAR: near_d = wr_w;
                `WCS_OFS_MD: md_d = wr_w;
                `WCS_OFS_DZRNG: dzrng_d = wr_w;
                `WCS_OFS_TOTLIM: totlim_d = wdata_i;
                default: ;
            endcase
        end
        if (dz_req && gross_abs <= dzrng_q)
        begin
            zero_d = weight_i;
        end
        if (re_i)
        begin
            case (addr_i)
                `WCS_OFS_CTRL: rdata_d = {25'h0, ctrl_q};
                `WCS_OFS_CODE: rdata_d = 32'(code_q);
                `WCS_OFS_SP1: rdata_d = 32'(set.sp1);
                `WCS_OFS_SP2: rdata_d = 32'(set.sp2);
                `WCS_OFS_SP3: rdata_d = 32'(set.sp3);
                `WCS_OFS_FINAL: rdata_d = 32'(set.final_w);
                `WCS_OFS_OVER: rdata_d = 32'(set.over_tol);
                `WCS_OFS_UNDER: rdata_d = 32'(set.under_tol);
                `WCS_OFS_UPPER: rdata_d = 32'(upper_q);
                `WCS_OFS_LOWER: rdata_d = 32'(lower_q);
                `WCS_OFS_NEAR: rdata_d = 32'(near_q);
                `WCS_OFS_MD: rdata_d = 32'(md_q);
                `WCS_OFS_DZRNG: rdata_d = 32'(dzrng_q);
                `WCS_OFS_TOTLIM: rdata_d = totlim_q;
                `WCS_OFS_STATUS: rdata_d = 32'(flags_q);
                `WCS_OFS_TALLY: rdata_d = 32'(bank_bus.tally);
                `WCS_OFS_TOTAL: rdata_d = bank_bus.total;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q <= '0;
            code_q <= '0;
            upper_q <= '0;
            lower_q <= '0;
            near_q <= '0;
            md_q <= '0;
            dzrng_q <= '0;
            totlim_q <= '0;
            zero_q <= '0;
            rdata_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            code_q <= code_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
            near_q <= near_d;
            md_q <= md_d;
            dzrng_q <= dzrng_d;
            totlim_q <= totlim_d;
            zero_q <= zero_d;
            rdata_q <= rdata_d;
        end
    end
    assign rdata_o = rdata_q;

    // sequence, setpoints and status flags
    always_comb
    begin
        state_d = state_q;
        flags_d = flags_q;
        base_d = base_q;
        inc = 1'b0;
        if (discharge_active_flag_now != discharge_active_flag_q)
        begin
            base_d = wt;
        end
        if (!ctrl_q[`WCS_CTRL_SEQ])
        begin
            state_d = WCS_IDLE;
            flags_d[2:0] = cmp_simple;
        end
        else if (stop_req)
        begin
            state_d = WCS_IDLE;
            flags_d[2:0] = 3'h0;
        end
        else
        begin
            case (state_q)
                WCS_IDLE, WCS_DONE:
                begin
                    if (start_req)
                    begin
                        state_d = WCS_FEED;
                        flags_d[2:0] = 3'h7;
                        flags_d[`WCS_ST_UNDER:`WCS_ST_DONE] = '0;
                        base_d = wt;
                    end
                end
                WCS_FEED:
                begin
                    flags_d[2:0] = flags_q[2:0] & ~reach;
                    if (flags_d[2:0] == 3'h0)
                    begin
                        state_d = WCS_JUDGE;
                    end
                end
                WCS_JUDGE:
                begin
                    if (settled)
                    begin
                        state_d = WCS_DONE;
                        inc = 1'b1;
                        flags_d[`WCS_ST_DONE] = 1'b1;
                        if (amount > set.final_w + set.over_tol)
                        begin
                            flags_d[`WCS_ST_OVER] = 1'b1;
                        end
                        else if (amount < set.final_w - set.under_tol)
                        begin
                            flags_d[`WCS_ST_UNDER] = 1'b1;
                        end
                        else
                        begin
                            flags_d[`WCS_ST_GO] = 1'b1;
                        end
                    end
                end
                default: state_d = WCS_IDLE;
            endcase
        end
        flags_d[`WCS_ST_DISCHARGE_ACTIVE_FLAG] = discharge_active_flag_now;
        flags_d[`WCS_ST_HI] = wt > upper_q;
        flags_d[`WCS_ST_LO] = wt < lower_q;
        flags_d[`WCS_ST_NZ] = wt <= near_q;
        flags_d[`WCS_ST_WEIGHT_SETTLED_FLAG] = settled;
        if (dz_req)
        begin
            flags_d[`WCS_ST_ZERO_RANGE_ALARM] = gross_abs > dzrng_q;
        end
        flags_d[`WCS_ST_HLOCK] = hw_lock_i;
        flags_d[`WCS_ST_SLOCK] = ctrl_q[`WCS_CTRL_SLOCK];
        flags_d[`WCS_ST_TOTAL_LIMIT_FLAG] = totlim_q != '0 && bank_bus.total >= totlim_q;
        flags_d[`WCS_ST_NOV] = nvm_busy_i;
        flags_d[`WCS_ST_RUN] = !nvm_busy_i && !flags_d[`WCS_ST_TOTAL_LIMIT_FLAG];
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= WCS_IDLE;
            flags_q <= '0;
            base_q <= '0;
            ext_start_q <= 1'b0;
            ext_stop_q <= 1'b0;
            discharge_active_flag_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            flags_q <= flags_d;
            base_q <= base_d;
            ext_start_q <= ext_start_i;
            ext_stop_q <= ext_stop_i;
            discharge_active_flag_q <= discharge_active_flag_now;
        end
    end

    // outputs straight from the flag register
    assign setpoint_out_first_o = flags_q[`WCS_ST_SP1];
    assign setpoint_out_second_o = flags_q[`WCS_ST_SP1+1];
    assign setpoint_out_third_o = flags_q[`WCS_ST_SP1+2];
    assign cycle_done_flag_o = flags_q[`WCS_ST_DONE];
    assign discharge_active_flag_o = flags_q[`WCS_ST_DISCHARGE_ACTIVE_FLAG];
    assign over_flag_o = flags_q[`WCS_ST_OVER];
    assign go_flag_o = flags_q[`WCS_ST_GO];
    assign under_flag_o = flags_q[`WCS_ST_UNDER];
    assign upper_limit_flag_o = flags_q[`WCS_ST_HI];
    assign beneath_min_flag_o = flags_q[`WCS_ST_LO];
    assign near_null_flag_o = flags_q[`WCS_ST_NZ];
    assign weight_settled_flag_o = flags_q[`WCS_ST_WEIGHT_SETTLED_FLAG];
    assign zero_range_alarm_o = flags_q[`WCS_ST_ZERO_RANGE_ALARM];
    assign hw_lock_flag_o = flags_q[`WCS_ST_HLOCK];
    assign soft_lock_flag_o = flags_q[`WCS_ST_SLOCK];
    assign total_limit_flag_o = flags_q[`WCS_ST_TOTAL_LIMIT_FLAG];
    assign run_flag_o = flags_q[`WCS_ST_RUN];
    assign nov_flag_o = flags_q[`WCS_ST_NOV];

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_simple_cmp;
        !ctrl_q[`WCS_CTRL_SEQ] |=> flags_q[2:0] == $past(cmp_simple);
    endproperty
    a_simple_cmp: assert property (p_simple_cmp) else $error("simple setpoints wrong");
    property p_start_all;
        ctrl_q[`WCS_CTRL_SEQ] && state_q == WCS_IDLE && start_req && !stop_req
            |=> flags_q[2:0] == 3'h7 ##1 state_q == WCS_FEED || flags_q[2:0] != 3'h7;
    endproperty
    a_start_all: assert property (p_start_all) else $error("start did not raise setpoints");
    property p_drop;
        ctrl_q[`WCS_CTRL_SEQ] && state_q == WCS_FEED && !stop_req && flags_q[0] && reach[0]
            |=> !flags_q[0];
    endproperty
    a_drop: assert property (p_drop) else $error("first setpoint did not drop");
    property p_onehot;
        state_q == WCS_DONE |-> $onehot(flags_q[`WCS_ST_UNDER:`WCS_ST_OVER]);
    endproperty
    a_onehot: assert property (p_onehot) else $error("result not one-hot");
    property p_near;
        1'b1 |=> flags_q[`WCS_ST_NZ] == $past(wt <= near_q);
    endproperty
    a_near: assert property (p_near) else $error("near zero flag wrong");
    property p_limits;
        1'b1 |=> flags_q[`WCS_ST_HI] == $past(wt > upper_q)
            && flags_q[`WCS_ST_LO] == $past(wt < lower_q);
    endproperty
    a_limits: assert property (p_limits) else $error("limit flags wrong");
    property p_zero_range_alarm;
        dz_req && gross_abs > dzrng_q |=> flags_q[`WCS_ST_ZERO_RANGE_ALARM] && $stable(zero_q);
    endproperty
    a_zero_range_alarm: assert property (p_zero_range_alarm) else $error("zero alarm missing");
    property p_lock;
        hw_lock_i && we_i && addr_i == `WCS_OFS_UPPER |=> $stable(upper_q);
    endproperty
    a_lock: assert property (p_lock) else $error("locked write accepted");
    property p_nov;
        nvm_busy_i |=> flags_q[`WCS_ST_NOV] && !flags_q[`WCS_ST_RUN];
    endproperty
    a_nov: assert property (p_nov) else $error("write indication wrong");
    property p_sat;
        inc && bank_bus.tally == `WCS_TALLY_MAX && !aclr_req
            && !(we_i && addr_i == `WCS_OFS_CODE) |=> bank_bus.tally == `WCS_TALLY_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("tally passed limit");
    property p_clr;
        aclr_req && !(we_i && addr_i == `WCS_OFS_CODE) |=> bank_bus.tally == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear missed");
    c_cycle: cover property (state_q == WCS_JUDGE ##1 state_q == WCS_DONE);
    c_zero_range_alarm: cover property (dz_req && gross_abs > dzrng_q);
    c_stop: cover property (state_q == WCS_FEED && stop_req);
endmodule // wcs_top

// [test/wcs_panel_model.sv]
`timescale 1ns/1ps
// panel and connector stand-in: a start press becomes a level on the line
module wcs_panel_model
(
    // clock
    input wire logic clk_i,
    // press request from the bench
    input wire logic press_i,
    // connector start line
    output logic ext_start_o
);
    logic [1:0] hold_q = 2'h0;
    // hold the line for three clocks, then release it low
    always_ff @(posedge clk_i)
    begin
        if (press_i)
            hold_q <= 2'h3;
        else if (hold_q != 2'h0)
            hold_q <= hold_q - 2'h1;
    end
    assign ext_start_o = (hold_q != 2'h0);
endmodule // wcs_panel_model

// [test/tb_wcs_top.sv]
`timescale 1ns/1ps
`include "wcs_regs.svh"
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module tb_wcs_top;
    import wcs_pkg::*;
    logic clk_i, rst_n_i, we_i, re_i, ext_start_i, hw_lock_i, nvm_busy_i, press;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, rv;
    wcs_weight_type weight_i;
    logic sp1, sp2, sp3, done, discharge_active_flag, over, go, under, hi, lo, nz, weight_settled_flag, zero_range_alarm;
    logic hlk, slk, tlim, run, nov;
    logic stop, discharge_active_flag_in;
    int n_errors = 0;
    int num_checks = 0;
    wcs_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .weight_i(weight_i),
        .ext_start_i(ext_start_i), .ext_stop_i(stop), .ext_discharge_active_flag_i(discharge_active_flag_in),
        .hw_lock_i(hw_lock_i), .nvm_busy_i(nvm_busy_i), .setpoint_out_first_o(sp1),
        .setpoint_out_second_o(sp2), .setpoint_out_third_o(sp3), .cycle_done_flag_o(done),
        .discharge_active_flag_o(discharge_active_flag), .over_flag_o(over), .go_flag_o(go),
        .under_flag_o(under), .upper_limit_flag_o(hi), .beneath_min_flag_o(lo),
        .near_null_flag_o(nz), .weight_settled_flag_o(weight_settled_flag), .zero_range_alarm_o(zero_range_alarm),
        .hw_lock_flag_o(hlk), .soft_lock_flag_o(slk), .total_limit_flag_o(tlim),
        .run_flag_o(run), .nov_flag_o(nov));
    wcs_panel_model u_panel (.clk_i(clk_i), .press_i(press), .ext_start_o(ext_start_i));
    // clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // one-cycle register write
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask
    // one-cycle read, data taken in the following cycle
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // new weight, then let the registered flags settle
    task wt(input int w);
        @(posedge clk_i);
        weight_i <= w[23:0];
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    // simple comparison, limits and near zero
    task t_simple;
        wr(`WCS_OFS_SP1, 32'h0000000A);
        wr(`WCS_OFS_SP2, 32'h00000014);
        wr(`WCS_OFS_SP3, 32'h0000001E);
        wr(`WCS_OFS_FINAL, 32'h0000001E);
        wr(`WCS_OFS_OVER, 32'h00000005);
        wr(`WCS_OFS_UNDER, 32'h00000005);
        wr(`WCS_OFS_UPPER, 32'h00000028);
        wr(`WCS_OFS_LOWER, 32'h00000005);
        wr(`WCS_OFS_NEAR, 32'h00000003);
        wt(25);
        `CHK("sp", 3'b110, {sp1, sp2, sp3})
        `CHK("hi_lo_nz", 3'b000, {hi, lo, nz})
        wt(2);
        `CHK("sp_low", 3'b000, {sp1, sp2, sp3})
        `CHK("lo_nz", 3'b011, {hi, lo, nz})
        wt(50);
        `CHK("hi", 3'b100, {hi, lo, nz})
    endtask
    // started cycle: all on, staged drop, judgement and tallies
    task t_seq;
        int i;
        wt(0);
        wr(`WCS_OFS_CTRL, 32'h00000001);
        @(posedge clk_i);
        press <= 1'b1;
        @(posedge clk_i);
        press <= 1'b0;
        wt(0);
        `CHK("all_on", 3'b111, {sp1, sp2, sp3})
        wt(15);
        `CHK("first_off", 3'b011, {sp1, sp2, sp3})
        wt(25);
        `CHK("second_off", 3'b001, {sp1, sp2, sp3})
        wt(30);
        for (i = 0; i < 60 && done !== 1'b1; i++)
            @(posedge clk_i);
        #1;
        `CHK("done", 1'b1, done)
        `CHK("weight_settled_flag", 1'b1, weight_settled_flag)
        `CHK("judge", 3'b010, {over, go, under})
        rd(`WCS_OFS_TALLY, rv);
        `CHK("tally", 32'h00000001, rv)
        rd(`WCS_OFS_TOTAL, rv);
        `CHK("total", 32'h0000001E, rv)
        wr(`WCS_OFS_CODE, 32'h00000001);
        rd(`WCS_OFS_TOTAL, rv);
        `CHK("other_total", 32'h00000000, rv)
        wr(`WCS_OFS_CODE, 32'h00000000);
    endtask
    // lock sources, refused write, digital zero alarm, memory write
    task t_misc;
        hw_lock_i <= 1'b1;
        wr(`WCS_OFS_SP1, 32'h00000007);
        rd(`WCS_OFS_SP1, rv);
        `CHK("locked_sp1", 32'h0000000A, rv)
        `CHK("locks", 2'b10, {hlk, slk})
        hw_lock_i <= 1'b0;
        wr(`WCS_OFS_CTRL, 32'h00000004);
        wt(50);
        `CHK("soft_lock", 2'b01, {hlk, slk})
        wr(`WCS_OFS_CTRL, 32'h00000020);
        wt(50);
        `CHK("zero_range_alarm", 1'b1, zero_range_alarm)
        `CHK("run", 3'b100, {run, nov, tlim})
        nvm_busy_i <= 1'b1;
        wt(50);
        `CHK("nov", 2'b01, {run, nov})
        rd(8'hFC, rv);
        `CHK("unmapped", 32'h00000000, rv)
    endtask
    // connector stop, discharge switch, total limit and clear
    task t_stop;
        wt(0);
        wr(`WCS_OFS_CTRL, 32'h00000001);
        wr(`WCS_OFS_CTRL, 32'h00000009);
        wt(0);
        `CHK("restart", 4'hE, {sp1, sp2, sp3, done})
        @(posedge clk_i);
        discharge_active_flag_in <= 1'b1;
        wt(-15);
        `CHK("discharge_active_flag_drop", 4'h7, {sp1, sp2, sp3, discharge_active_flag})
        @(posedge clk_i);
        stop <= 1'b1;
        wt(-15);
        `CHK("stopped", 3'b000, {sp1, sp2, sp3})
        @(posedge clk_i);
        {stop, discharge_active_flag_in} <= 2'b00;
        wr(`WCS_OFS_TOTLIM, 32'h0000001E);
        wt(-15);
        `CHK("tlim", 1'b1, tlim)
        wr(`WCS_OFS_CTRL, 32'h00000040);
        rd(`WCS_OFS_TALLY, rv);
        `CHK("cleared", 32'h00000000, rv)
    endtask
    // verdict and end of run
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #200000;
        n_errors++;
        give_verdict;
    end
    // main sequence
    initial
    begin
        rst_n_i = 1'b0;
        {we_i, re_i, hw_lock_i, nvm_busy_i, press, stop, discharge_active_flag_in} = 7'h00;
        addr_i = 8'h00;
        wdata_i = 32'h00000000;
        weight_i = '0;
        repeat (16) @(posedge clk_i);
        #1;
        `CHK("reset_out", 4'h0, {sp1, sp2, sp3, run})
        rst_n_i <= 1'b1;
        t_simple;
        t_seq;
        t_misc;
        t_stop;
        give_verdict;
    end
endmodule // tb_wcs_top
